// ==== core/ocm_pkg.sv ====
/*
 * Shared constants for the over-range / clock output mux block.
 * Assumes a single 25 MHz clock domain and a plain register port.
 */
package ocm_pkg;
    // -----------------------------------------------------------------
    // Register offsets and fields
    // -----------------------------------------------------------------
    localparam logic [3:0] OCM_REG_CTRL = 4'h0;
    localparam logic [3:0] OCM_REG_THRESH = 4'h1;
    localparam logic [3:0] OCM_REG_HOLD = 4'h2;
    localparam logic [3:0] OCM_REG_STATUS = 4'h3;
    localparam logic [3:0] OCM_REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] OCM_REG_IRQ_CLR = 4'h5;
    localparam logic [3:0] OCM_REG_IRQ_EN = 4'h6;
    localparam int OCM_CTRL_OVR_EN = 0;
    localparam int OCM_CTRL_OVR_DIS = 1;
    localparam int OCM_CTRL_C_LO = 2;
    localparam int OCM_CTRL_D_LO = 4;
    localparam logic [5:0] OCM_CTRL_RST = 6'h00;
    localparam logic [8:0] OCM_THRESH_RST = 9'h0ff;
    localparam logic [7:0] OCM_HOLD_RST = 8'h04;
    localparam logic [1:0] OCM_CFG_OFF = 2'h0;
    localparam logic [1:0] OCM_CFG_DIV1 = 2'h1;
    localparam logic [1:0] OCM_CFG_DIV2 = 2'h2;
    localparam logic [1:0] OCM_CFG_DIV4 = 2'h3;
    localparam logic [1:0] OCM_NUM_CHANNELS_QUAD = 2'h3;
endpackage : ocm_pkg

// ==== core/ocm_mux.sv ====
/*
 * Channel C/D status pins: over-range flags or repeated reference clocks.
 * Assumes a synchronous environment on mclk; the reference clock and the
 * converter samples arrive as ordinary synchronous inputs.
 */
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ocm_mux #(
    parameter logic [1:0] OCM_VARIANT = 2'h3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Device pins
    input wire logic clock_out_config_bit0,
    input wire logic clock_out_config_bit1,
    input wire logic power_down_pin,
    input wire logic pll_enable_pin,
    input wire logic ref_single_ended_select,
    input wire logic diff_ref_in,
    input wire logic single_ended_ref_in,
    // Converter samples, magnitude per channel
    input wire logic [8:0] sample_mag_c,
    input wire logic [8:0] sample_mag_d,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Outputs
    output logic range_flag_c_pin,
    output logic range_flag_d_pin,
    output logic refclk_repeat_out,
    output logic pll_active,
    output logic power_save,
    output logic irq
);
    import ocm_pkg::*;

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [5:0] ctrl;
    logic [8:0] overrange_threshold;
    logic [7:0] overrange_hold_count;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [7:0] hold_c;
    logic [7:0] hold_d;
    logic flag_c;
    logic flag_d;
    logic [1:0] div_cnt;
    logic ref_q;
    logic next_ref;
    logic ref_rise;
    logic [1:0] cfg_pins;
    logic [1:0] cfg_c;
    logic [1:0] cfg_d;
    logic clk_mode;
    logic quad;
    logic over_c;
    logic over_d;

    function automatic logic ocm_pick(input logic [1:0] cfg, input logic r,
                                      input logic [1:0] cnt);
        case (cfg)
            OCM_CFG_DIV1: ocm_pick = r;
            OCM_CFG_DIV2: ocm_pick = cnt[0];
            OCM_CFG_DIV4: ocm_pick = cnt[1];
            default: ocm_pick = 1'b0;
        endcase
    endfunction : ocm_pick

    // Register writes; the serial override only acts when its enable is set.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl <= OCM_CTRL_RST;
            overrange_threshold <= OCM_THRESH_RST;
            overrange_hold_count <= OCM_HOLD_RST;
            irq_en <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                OCM_REG_CTRL: ctrl <= reg_wdata[5:0];
                OCM_REG_THRESH: overrange_threshold <= reg_wdata[8:0];
                OCM_REG_HOLD: overrange_hold_count <= reg_wdata[7:0];
                OCM_REG_IRQ_EN: irq_en <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Reference selection and mode decode
    // -----------------------------------------------------------------
    assign next_ref = ref_single_ended_select ? single_ended_ref_in : diff_ref_in;
    assign pll_active = pll_enable_pin & ~power_down_pin;
    assign power_save = power_down_pin;
    assign cfg_pins = {clock_out_config_bit1, clock_out_config_bit0};
    assign quad = (OCM_VARIANT == OCM_NUM_CHANNELS_QUAD);
    // Pins work without any write, so a clock is there from power-up.
    assign cfg_c = ctrl[OCM_CTRL_OVR_EN] ?
        (ctrl[OCM_CTRL_OVR_DIS] ? OCM_CFG_OFF : ctrl[OCM_CTRL_C_LO +: 2]) : cfg_pins;
    // D follows pins only as an undivided copy; dividers need the override.
    assign cfg_d = (cfg_c == OCM_CFG_OFF) ? OCM_CFG_OFF :
        (ctrl[OCM_CTRL_OVR_EN] ? ctrl[OCM_CTRL_D_LO +: 2] : OCM_CFG_DIV1);
    assign clk_mode = pll_enable_pin & ~power_down_pin;
    assign ref_rise = next_ref & ~ref_q;

    // Repeated reference register; stopped during power-down.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= power_down_pin ? 1'b0 : next_ref;
        end
    end

    // Divider counter advances on reference rising edges; cleared when off.
    always_ff @(posedge mclk) begin
        if (!rst_n || power_down_pin || !pll_enable_pin) begin
            div_cnt <= 2'h0;
        end else if (ref_rise) begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    // -----------------------------------------------------------------
    // Over-range detection with minimum hold
    // -----------------------------------------------------------------
    assign over_c = quad && (sample_mag_c > overrange_threshold);
    assign over_d = quad && (sample_mag_d > overrange_threshold);

    // Each flag restarts its hold count on every exceedance.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_c <= 8'h00;
            flag_c <= 1'b0;
        end else if (over_c) begin
            flag_c <= 1'b1;
            hold_c <= overrange_hold_count;
        end else if (hold_c > 8'h01) begin
            hold_c <= hold_c - 8'h01;
        end else begin
            hold_c <= 8'h00;
            flag_c <= 1'b0;
        end
    end

    // Channel D keeps its own hold count, so one channel never stretches the other.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_d <= 8'h00;
            flag_d <= 1'b0;
        end else if (over_d) begin
            flag_d <= 1'b1;
            hold_d <= overrange_hold_count;
        end else if (hold_d > 8'h01) begin
            hold_d <= hold_d - 8'h01;
        end else begin
            hold_d <= 8'h00;
            flag_d <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Pin outputs, registered
    // -----------------------------------------------------------------
    // Clock modes are gated by clk_mode, so a stopped PLL leaves the pins low, not frozen high.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            range_flag_c_pin <= 1'b0;
            range_flag_d_pin <= 1'b0;
            refclk_repeat_out <= 1'b0;
        end else begin
            refclk_repeat_out <= pll_active ? next_ref : 1'b0;
            if (cfg_c == OCM_CFG_OFF) begin
                range_flag_c_pin <= flag_c;
            end else begin
                range_flag_c_pin <= clk_mode & ocm_pick(cfg_c, next_ref, div_cnt);
            end
            if (cfg_d == OCM_CFG_OFF) begin
                range_flag_d_pin <= flag_d;
            end else begin
                range_flag_d_pin <= clk_mode & ocm_pick(cfg_d, next_ref, div_cnt);
            end
        end
    end

    // -----------------------------------------------------------------
    // Interrupts: sticky over-range events, set wins over clear
    // -----------------------------------------------------------------
    // A clear that meets a new event in the same cycle loses, so no event is missed.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_stat <= 2'h0;
        end else begin
            irq_stat <= (irq_stat & ~((reg_wr && reg_addr == OCM_REG_IRQ_CLR) ?
                        reg_wdata[1:0] : 2'h0)) | {over_d, over_c};
        end
    end
    // The interrupt is a level; it drops only when software clears or masks the event.
    assign irq = |(irq_stat & irq_en);

    // Read data, valid the cycle after the read strobe.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                OCM_REG_CTRL: reg_rdata <= {10'h000, ctrl};
                OCM_REG_THRESH: reg_rdata <= {7'h00, overrange_threshold};
                OCM_REG_HOLD: reg_rdata <= {8'h00, overrange_hold_count};
                OCM_REG_STATUS: reg_rdata <= {10'h000, cfg_c, cfg_d, flag_d, flag_c};
                OCM_REG_IRQ_STAT: reg_rdata <= {14'h0000, irq_stat};
                OCM_REG_IRQ_EN: reg_rdata <= {14'h0000, irq_en};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    // Flag capture: an exceedance always raises the flag on the next edge.
    a_flag_c_set: assert property (@(posedge mclk) disable iff (!rst_n)
        over_c |=> flag_c) else $error("flag c not set");
    a_flag_d_set: assert property (@(posedge mclk) disable iff (!rst_n)
        over_d |=> flag_d) else $error("flag d not set");
    a_flag_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (over_c && overrange_hold_count >= 8'h02) |=> flag_c[*2]) else $error("hold short");
    a_hold_d_min: assert property (@(posedge mclk) disable iff (!rst_n)
        (over_d && overrange_hold_count >= 8'h02) |=> flag_d[*2]) else $error("hold d short");
    a_variant_only: assert property (@(posedge mclk) disable iff (!rst_n)
        !quad |-> !over_c && !over_d) else $error("flag outside quad");

    // Flag mode: each pin shows its flag one edge late.
    a_flag_mode_c: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_c == OCM_CFG_OFF) |=> range_flag_c_pin == $past(flag_c)) else $error("c flag");
    a_flag_mode_d: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_d == OCM_CFG_OFF) |=> range_flag_d_pin == $past(flag_d)) else $error("d flag");

    // Clock mode on C: the pin copies the reference or one divider bit.
    a_c_ref_copy: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_c == OCM_CFG_DIV1 && clk_mode) |=> range_flag_c_pin == $past(next_ref))
        else $error("c not ref copy");
    a_c_half_rate: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_c == OCM_CFG_DIV2 && clk_mode) |=> range_flag_c_pin == $past(div_cnt[0]))
        else $error("c not half rate");
    a_c_quarter_rate: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_c == OCM_CFG_DIV4 && clk_mode) |=> range_flag_c_pin == $past(div_cnt[1]))
        else $error("c not quarter rate");

    // A clock mode with the PLL off or powered down keeps the pins low.
    a_c_clock_off: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_c != OCM_CFG_OFF && !clk_mode) |=> !range_flag_c_pin) else $error("c clock runs");
    a_d_clock_off: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_d != OCM_CFG_OFF && !clk_mode) |=> !range_flag_d_pin) else $error("d clock runs");
    a_pd_stops: assert property (@(posedge mclk) disable iff (!rst_n)
        power_down_pin |=> !refclk_repeat_out) else $error("ref not stopped");
    a_ref_needs_pll: assert property (@(posedge mclk) disable iff (!rst_n)
        !pll_enable_pin |=> !refclk_repeat_out) else $error("ref without pll");

    // D decode: never alone, and only undivided when set from the pins.
    a_d_needs_c: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_d != OCM_CFG_OFF |-> cfg_c != OCM_CFG_OFF) else $error("d without c");
    a_d_pins_div1: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ctrl[OCM_CTRL_OVR_EN] && cfg_pins != 2'h0) |-> cfg_d == OCM_CFG_DIV1)
        else $error("d div on pins");

    // Divider: cleared while off, one step per reference rise while running.
    a_div_held: assert property (@(posedge mclk) disable iff (!rst_n)
        !pll_enable_pin |=> div_cnt == 2'h0) else $error("divider runs");
    a_div_step: assert property (@(posedge mclk) disable iff (!rst_n)
        (pll_active && ref_rise) |=> div_cnt == $past(div_cnt) + 2'h1)
        else $error("divider stuck");

    // Main scenarios that the bench is expected to reach.
    c_flag_pulse: cover property (@(posedge mclk) disable iff (!rst_n) over_c ##1 flag_c);
    c_div4_mode: cover property (@(posedge mclk) disable iff (!rst_n) cfg_c == OCM_CFG_DIV4);
    c_irq_raise: cover property (@(posedge mclk) disable iff (!rst_n) irq);
    c_d_half_rate: cover property (@(posedge mclk) disable iff (!rst_n) cfg_d == OCM_CFG_DIV2);
endmodule : ocm_mux
`default_nettype wire

// ==== bench/ocm_far_end.sv ====
/*
 * Far-end receiver model: counts rising edges on both status pins and
 * on the repeated reference. Assumes every pin is synchronous to mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module ocm_far_end (
    // Clock and control
    input wire logic mclk,
    input wire logic clr,
    // Pins watched
    input wire logic c_pin,
    input wire logic d_pin,
    input wire logic ref_pin,
    // Edge counts
    output logic [7:0] edges_c,
    output logic [7:0] edges_d,
    output logic [7:0] edges_r
);
    // -----------------------------------------------------------------
    // Edge counters
    // -----------------------------------------------------------------
    logic [2:0] last;

    // Sampling on mclk is enough, since the pins are registered on it.
    always_ff @(posedge mclk) begin
        last <= {ref_pin, d_pin, c_pin};
        if (clr) begin
            edges_c <= 8'h00;
            edges_d <= 8'h00;
            edges_r <= 8'h00;
        end else begin
            edges_c <= edges_c + {7'h00, c_pin & ~last[0]};
            edges_d <= edges_d + {7'h00, d_pin & ~last[1]};
            edges_r <= edges_r + {7'h00, ref_pin & ~last[2]};
        end
    end
endmodule : ocm_far_end
`default_nettype wire

// ==== bench/ocm_mux_bench.sv ====
/*
 * Self-checking bench for the status pin mux.
 * Assumes the design package and ocm_far_end are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module ocm_mux_bench;
    import ocm_pkg::*;
    // -----------------------------------------------------------------
    // Stimulus and wiring
    // -----------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg0 = 1'b0, cfg1 = 1'b0, pd = 1'b0, pll_en = 1'b1, sel = 1'b0;
    logic dref = 1'b0, sref = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0;
    logic [8:0] mag_c = 9'h000, mag_d = 9'h000;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, rv;
    logic flag_c, flag_d, ref_out, pll_act, psave, irq;
    logic [7:0] e_c, e_d, e_r;
    logic [2:0] phase = 3'h0;
    logic [5:0] ctl_tab [5] = '{6'h25, 6'h35, 6'h21, 6'h07, 6'h19};
    int fails = 0, checked = 0, thr, hold, hi;

    // Free-running 25 MHz clock.
    initial begin
        forever #20 mclk = ~mclk;
    end

    // Reference clocks: differential at mclk/4, single-ended at mclk/8.
    always @(posedge mclk) begin
        phase <= phase + 3'h1;
        dref <= phase[1];
        sref <= phase[2];
    end

    ocm_mux dut_u (.mclk(mclk), .rst_n(rst_n), .clock_out_config_bit0(cfg0),
        .clock_out_config_bit1(cfg1), .power_down_pin(pd), .pll_enable_pin(pll_en),
        .ref_single_ended_select(sel), .diff_ref_in(dref), .single_ended_ref_in(sref),
        .sample_mag_c(mag_c), .sample_mag_d(mag_d), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .range_flag_c_pin(flag_c),
        .range_flag_d_pin(flag_d), .refclk_repeat_out(ref_out), .pll_active(pll_act),
        .power_save(psave), .irq(irq));
    ocm_far_end far_u (.mclk(mclk), .clr(clr), .c_pin(flag_c), .d_pin(flag_d),
        .ref_pin(ref_out), .edges_c(e_c), .edges_d(e_d), .edges_r(e_r));

    // -----------------------------------------------------------------
    // Expectations, bus cycles and comparisons
    // -----------------------------------------------------------------
    function automatic int exp_edges(input logic [1:0] code);
        return (code == 2'h0) ? 0 : (16 >> (code - 2'h1));
    endfunction : exp_edges

    // A disabled or flag-mode C pin also silences D.
    function automatic int exp_ovr(input logic [5:0] c, input bit d);
        if (c[1] || c[3:2] == 2'h0) return 0;
        return exp_edges(d ? c[5:4] : c[3:2]);
    endfunction : exp_ovr

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Edge counts depend on reference phase, so nonzero figures get one edge of slack.
    task automatic chk_near(input logic [7:0] got, input int exp);
        checked++;
        if (got !== 8'(exp) && !(exp > 0 && (got === 8'(exp + 1) || got === 8'(exp - 1)))) begin
            fails++;
            $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_near

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : rd_reg

    task automatic measure();
        repeat (4) @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (64) @(posedge mclk);
        @(negedge mclk);
    endtask : measure

    // One magnitude sample on a channel, then count cycles with the flag high.
    task automatic pulse(input int ch, input int v, output int n);
        @(posedge mclk);
        if (ch == 1) mag_d <= 9'(v);
        else mag_c <= 9'(v);
        @(posedge mclk);
        mag_c <= 9'h000;
        mag_d <= 9'h000;
        n = 0;
        repeat (20) begin
            @(negedge mclk);
            if (((ch == 1) ? flag_d : flag_c) === 1'b1) n++;
        end
    endtask : pulse

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // Watchdog so a hang still reaches the verdict.
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        void'($urandom(5923));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(OCM_REG_THRESH, rv);
        chk(rv, 16'(OCM_THRESH_RST));
        rd_reg(OCM_REG_HOLD, rv);
        chk(rv, 16'(OCM_HOLD_RST));
        rd_reg(4'hf, rv);
        chk(rv, 16'h0000);
        chk(16'(pll_act), 16'h0001);
        chk(16'(psave), 16'h0000);
        $display("reset test done");
        for (int ch = 0; ch < 2; ch++) begin
            thr = $urandom_range(9'h1f0, 9'h040);
            hold = $urandom_range(6, 2);
            wr_reg(OCM_REG_THRESH, 16'(thr));
            wr_reg(OCM_REG_HOLD, 16'(hold));
            pulse(ch, thr, hi);
            chk(16'(hi), 16'h0000);
            pulse(ch, thr + 1, hi);
            chk(16'(hi), 16'(hold));
            chk(16'(irq), 16'h0000);
            rd_reg(OCM_REG_IRQ_STAT, rv);
            chk(rv, 16'(1 << ch));
            wr_reg(OCM_REG_IRQ_EN, 16'h0003);
            @(negedge mclk);
            chk(16'(irq), 16'h0001);
            wr_reg(OCM_REG_IRQ_CLR, 16'(1 << ch));
            @(negedge mclk);
            chk(16'(irq), 16'h0000);
            wr_reg(OCM_REG_IRQ_EN, 16'h0000);
            rd_reg(OCM_REG_IRQ_STAT, rv);
            chk(rv, 16'h0000);
        end
        $display("flag test done");
        for (int code = 1; code < 4; code++) begin
            @(posedge mclk);
            cfg0 <= code[0];
            cfg1 <= code[1];
            rd_reg(OCM_REG_STATUS, rv);
            chk(rv, 16'({2'(code), OCM_CFG_DIV1, 2'h0}));
            measure();
            chk_near(e_c, exp_edges(2'(code)));
            chk_near(e_d, 16);
        end
        @(posedge mclk);
        cfg0 <= 1'b1;
        cfg1 <= 1'b0;
        sel <= 1'b1;
        measure();
        chk_near(e_r, 8);
        chk_near(e_c, 8);
        @(posedge mclk);
        sel <= 1'b0;
        pll_en <= 1'b0;
        measure();
        chk_near(e_c, 0);
        chk_near(e_r, 0);
        chk(16'(pll_act), 16'h0000);
        @(posedge mclk);
        pll_en <= 1'b1;
        pd <= 1'b1;
        measure();
        chk_near(e_c, 0);
        chk_near(e_d, 0);
        chk_near(e_r, 0);
        chk(16'(psave), 16'h0001);
        @(posedge mclk);
        pd <= 1'b0;
        $display("pin clock test done");
        foreach (ctl_tab[i]) begin
            wr_reg(OCM_REG_CTRL, 16'(ctl_tab[i]));
            measure();
            chk_near(e_c, exp_ovr(ctl_tab[i], 1'b0));
            chk_near(e_d, exp_ovr(ctl_tab[i], 1'b1));
        end
        $display("override test done");
        wrap_up();
    end
endmodule : ocm_mux_bench
`default_nettype wire
